// ---- pkg/acmpc_pkg.sv ----
package acmpc_pkg;
  localparam int NUM_CMP = 4;
  localparam int NUM_AMP = 3;
  localparam int AW = 6;
  localparam int DW = 32;
  localparam int RW = 8;

  localparam logic [AW-1:0] OFF_CTRL0 = 6'h00;
  localparam logic [AW-1:0] OFF_CTRL1 = 6'h04;
  localparam logic [AW-1:0] OFF_CTRL2 = 6'h08;
  localparam logic [AW-1:0] OFF_CTRL3 = 6'h0C;
  localparam logic [AW-1:0] OFF_ADCB = 6'h10;
  localparam logic [AW-1:0] OFF_STATUS = 6'h14;
  localparam logic [AW-1:0] OFF_CONFIG = 6'h18;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 6'h1C;
  localparam logic [AW-1:0] OFF_IRQ_CLR = 6'h20;
  localparam logic [AW-1:0] OFF_IRQ_EN = 6'h24;

  localparam int ADCB_ISRC = 6;
  localparam int ADCB_REF_PIN = 5;
  localparam logic [RW-1:0] ADCB_WMASK = 8'hEF;
  localparam logic [RW-1:0] ADCB_RESET = 8'h00;
  localparam int CFG_HALF = 0;
  localparam int CFG_ROUTE_LO = 1;

  typedef enum logic [1:0] {
    SENSE_TOGGLE = 2'h0,
    SENSE_RSVD = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } acmpc_sense_t;

  typedef enum logic [2:0] {
    NEG_VREF_D640 = 3'h0,
    NEG_VREF_D320 = 3'h1,
    NEG_VREF_D213 = 3'h2,
    NEG_VREF_D160 = 3'h3,
    NEG_BANDGAP = 3'h4,
    NEG_DAC = 3'h5,
    NEG_PIN = 3'h6,
    NEG_RSVD = 3'h7
  } acmpc_neg_t;

  typedef struct packed {
    logic on;
    logic irqOn;
    acmpc_sense_t sense;
    logic aux;
    acmpc_neg_t negSel;
  } acmpc_ctrl_t;

  localparam acmpc_ctrl_t CTRL_RESET = 8'h00;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } acmpc_bus_st_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [AW-1:0] address;
    logic [DW-1:0] writedata;
    logic [DW/8-1:0] byteenable;
  } acmpc_avreq_t;

  typedef struct packed {
    logic pll;
    logic [NUM_AMP-1:0] amp;
  } acmpc_ticks_t;
endpackage : acmpc_pkg

// ---- core/acmpc_clk_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module acmpc_clk_div (
  input wire logic mclk,
  input wire logic reset,
  input wire logic half,
  output logic ioTick
);
  import acmpc_pkg::*;

  typedef struct packed {
    logic phase;
  } acmpc_div_st_t;

  acmpc_div_st_t st_q;
  acmpc_div_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.phase = ~st_q.phase;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // full rate, or every second cycle when halved
  assign ioTick = half ? st_q.phase : 1'b1;

  a_half_rate: assert property (@(posedge mclk) disable iff (reset)
    half && ioTick ##1 half |-> !ioTick)
    else $error("halved comparison tick ran two cycles in a row");
endmodule : acmpc_clk_div
`default_nettype wire

// ---- core/acmpc_cmp_sample.sv ----
`timescale 1ns/1ps
`default_nettype none
module acmpc_cmp_sample (
  input wire logic mclk,
  input wire logic reset,
  input wire logic on,
  input wire acmpc_pkg::acmpc_sense_t sense,
  input wire logic tick,
  input wire logic raw,
  output logic cmpOut,
  output logic cmpEvent
);
  import acmpc_pkg::*;

  typedef struct packed {
    logic out;
    logic evt;
  } acmpc_smp_st_t;

  acmpc_smp_st_t st_q;
  acmpc_smp_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.evt = 1'b0;
    if (!st_q.out && !on) begin
      st_d.out = 1'b0;
    end
    if (!on) begin
      st_d.out = 1'b0;
    end else if (tick) begin
      st_d.out = raw;
      unique case (sense)
        SENSE_TOGGLE: st_d.evt = raw ^ st_q.out;
        SENSE_FALL: st_d.evt = st_q.out & ~raw;
        SENSE_RISE: st_d.evt = ~st_q.out & raw;
        SENSE_RSVD: st_d.evt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cmpOut = st_q.out;
  assign cmpEvent = st_q.evt;

  a_sense_rise: assert property (@(posedge mclk) disable iff (reset)
    cmpEvent && $past(sense) == SENSE_RISE |-> cmpOut && !$past(cmpOut))
    else $error("rise event without a rising output");

  a_sample_hold: assert property (@(posedge mclk) disable iff (reset)
    on && !tick ##1 on |-> cmpOut == $past(cmpOut) && !cmpEvent)
    else $error("output changed without a comparison tick");
endmodule : acmpc_cmp_sample
`default_nettype wire

// ---- core/acmpc_ctrl.sv ----
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - output high while positive exceeds selected negative
// - compare each I/O clock or every second
// - four separate interrupts on rise, fall, toggle; the four flags share one irq output here
// - interrupt events drive converter sync triggers
// - comparator 1 output may feed timer capture
// - amplifier routing takes amplifier input and clock
// - control bit 7 turns comparator 0 on
// - control bit 6 enables comparator 0 interrupt
// - sense field: toggle, falling, rising, 01 reserved
// - control bit 3 picks PLL comparison clock
// - negative selector codes pick reference, DAC, pin
// - comparator 1 bits 7, 6: on, interrupt
// - converter register bit 6 switches current source
// - converter register bit 5 connects reference pin
module acmpc_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire acmpc_pkg::acmpc_avreq_t avReq,
  output logic avWaitrequest,
  output logic [acmpc_pkg::DW-1:0] avReaddata,
  input wire logic [acmpc_pkg::NUM_CMP-1:0] cmpRaw,
  input wire acmpc_pkg::acmpc_ticks_t clkTicks,
  output logic [acmpc_pkg::NUM_CMP-1:0] cmpOn,
  output acmpc_pkg::acmpc_neg_t [acmpc_pkg::NUM_CMP-1:0] cmpNegSel,
  output logic [acmpc_pkg::NUM_AMP-1:0] ampToCmpRoute,
  output logic [acmpc_pkg::NUM_CMP-1:0] cmpOutN,
  output logic [acmpc_pkg::NUM_CMP-1:0] syncTrigger,
  output logic timerCaptureIn,
  output logic currentSourceOn,
  output logic refPinConnect,
  output logic irq
);
  import acmpc_pkg::*;

  typedef struct packed {
    acmpc_bus_st_t bus;
    logic [DW-1:0] rdata;
    acmpc_ctrl_t [NUM_CMP-1:0] ctrl;
    logic [RW-1:0] adcB;
    logic half;
    logic [NUM_AMP-1:0] route;
    logic [NUM_CMP-1:0] flags;
    logic [NUM_CMP-1:0] irqEn;
  } acmpc_ctrl_st_t;

  acmpc_ctrl_st_t st_q;
  acmpc_ctrl_st_t st_d;

  localparam acmpc_ctrl_t CTRL_AUX_MASK = '{on: 1'b0, irqOn: 1'b0, sense: SENSE_TOGGLE,
                                           aux: 1'b1, negSel: NEG_VREF_D640};

  logic ioTick;
  logic [NUM_CMP-1:0] cmpTick;
  logic [NUM_CMP-1:0] cmpEvent;
  logic [NUM_CMP-1:0] ieBits;
  logic [NUM_CMP-1:0] clrBits;
  logic [RW-1:0] wByte;
  logic wrAck;
  logic rdStart;

  acmpc_clk_div u_div (
    .mclk(mclk),
    .reset(reset),
    .half(st_q.half),
    .ioTick(ioTick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      if (gi < NUM_AMP) begin : g_amp
        // routed comparator follows its amplifier clock
        assign cmpTick[gi] = st_q.route[gi] ? clkTicks.amp[gi]
                           : (st_q.ctrl[0].aux ? clkTicks.pll : ioTick);

        a_route_tick: assert property (@(posedge mclk) disable iff (reset)
          st_q.route[gi] |-> cmpTick[gi] == clkTicks.amp[gi])
          else $error("routed comparator ignores its amplifier clock");
      end else begin : g_plain
        assign cmpTick[gi] = st_q.ctrl[0].aux ? clkTicks.pll : ioTick;
      end
      acmpc_cmp_sample u_smp (
        .mclk(mclk),
        .reset(reset),
        .on(st_q.ctrl[gi].on),
        .sense(st_q.ctrl[gi].sense),
        .tick(cmpTick[gi]),
        .raw(cmpRaw[gi]),
        .cmpOut(cmpOutN[gi]),
        .cmpEvent(cmpEvent[gi])
      );
      assign cmpOn[gi] = st_q.ctrl[gi].on;
      assign ieBits[gi] = st_q.ctrl[gi].irqOn;
      assign cmpNegSel[gi] = st_q.ctrl[gi].negSel;

      a_flag_hold: assert property (@(posedge mclk) disable iff (reset)
        st_q.flags[gi] && !clrBits[gi] |=> st_q.flags[gi])
        else $error("comparator flag lost without a clear");

      a_flag_clear: assert property (@(posedge mclk) disable iff (reset)
        clrBits[gi] && !cmpEvent[gi] |=> !st_q.flags[gi])
        else $error("comparator flag survived its clear");

      a_flag_cause: assert property (@(posedge mclk) disable iff (reset)
        $rose(st_q.flags[gi]) |-> $past(cmpEvent[gi]))
        else $error("comparator flag set with no event");

      a_irq_each: assert property (@(posedge mclk) disable iff (reset)
        st_q.flags[gi] && st_q.irqEn[gi] && ieBits[gi] |-> irq)
        else $error("enabled comparator flag gave no interrupt");

      a_sync_cause: assert property (@(posedge mclk) disable iff (reset)
        syncTrigger[gi] |-> $past(cmpTick[gi] && cmpOn[gi]))
        else $error("sync trigger without a comparison tick");

      a_out_cause: assert property (@(posedge mclk) disable iff (reset)
        cmpOutN[gi] != $past(cmpOutN[gi]) |-> $past(cmpTick[gi] || !cmpOn[gi]))
        else $error("comparator output moved between ticks");

      a_out_follow: assert property (@(posedge mclk) disable iff (reset)
        $past(cmpTick[gi] && cmpOn[gi]) |-> cmpOutN[gi] == $past(cmpRaw[gi]))
        else $error("comparator output does not show the decision");

      a_rsvd_quiet: assert property (@(posedge mclk) disable iff (reset)
        $past(st_q.ctrl[gi].sense == SENSE_RSVD) |-> !syncTrigger[gi])
        else $error("reserved sense code gave an event");

      a_fall_only: assert property (@(posedge mclk) disable iff (reset)
        syncTrigger[gi] && $past(st_q.ctrl[gi].sense == SENSE_FALL) |-> !cmpOutN[gi])
        else $error("fall event while the output is high");

      a_event_change: assert property (@(posedge mclk) disable iff (reset)
        syncTrigger[gi] |-> cmpOutN[gi] != $past(cmpOutN[gi]))
        else $error("event without an output change");
    end
  endgenerate

  assign wByte = avReq.writedata[RW-1:0];
  // single wait cycle, then the access completes
  assign wrAck = avReq.write && st_q.bus == BUS_ACK && avReq.byteenable[0];
  assign rdStart = avReq.read && st_q.bus == BUS_IDLE;
  assign clrBits = (wrAck && avReq.address == OFF_IRQ_CLR) ? wByte[NUM_CMP-1:0] : '0;

  always_comb begin
    st_d = st_q;
    unique case (st_q.bus)
      BUS_IDLE: begin
        if (avReq.read || avReq.write) begin
          st_d.bus = BUS_ACK;
        end
      end
      BUS_ACK: begin
        st_d.bus = BUS_IDLE;
      end
    endcase
    if (rdStart) begin
      st_d.rdata = '0;
      unique case (avReq.address)
        OFF_CTRL0: st_d.rdata[RW-1:0] = st_q.ctrl[0];
        OFF_CTRL1: st_d.rdata[RW-1:0] = st_q.ctrl[1];
        OFF_CTRL2: st_d.rdata[RW-1:0] = st_q.ctrl[2];
        OFF_CTRL3: st_d.rdata[RW-1:0] = st_q.ctrl[3];
        OFF_ADCB: st_d.rdata[RW-1:0] = st_q.adcB;
        OFF_STATUS: st_d.rdata[RW-1:0] = {st_q.flags, cmpOutN};
        OFF_CONFIG: st_d.rdata[NUM_AMP:0] = {st_q.route, st_q.half};
        OFF_IRQ_STAT: st_d.rdata[NUM_CMP-1:0] = st_q.flags;
        OFF_IRQ_EN: st_d.rdata[NUM_CMP-1:0] = st_q.irqEn;
        default: st_d.rdata = '0;
      endcase
    end
    if (wrAck) begin
      unique case (avReq.address)
        OFF_CTRL0: st_d.ctrl[0] = wByte;
        OFF_CTRL1: st_d.ctrl[1] = wByte;
        OFF_CTRL2: st_d.ctrl[2] = wByte & ~CTRL_AUX_MASK;
        OFF_CTRL3: st_d.ctrl[3] = wByte & ~CTRL_AUX_MASK;
        OFF_ADCB: st_d.adcB = wByte & ADCB_WMASK;
        OFF_CONFIG: begin
          st_d.half = wByte[CFG_HALF];
          st_d.route = wByte[CFG_ROUTE_LO +: NUM_AMP];
        end
        OFF_IRQ_EN: st_d.irqEn = wByte[NUM_CMP-1:0];
        default: st_d.bus = BUS_IDLE;
      endcase
    end
    // a new event wins over a clear in the same cycle
    st_d.flags = (st_q.flags & ~clrBits) | cmpEvent;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '{bus: BUS_IDLE, rdata: '0, ctrl: {NUM_CMP{CTRL_RESET}},
                adcB: ADCB_RESET, half: 1'b0, route: '0, flags: '0, irqEn: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign avWaitrequest = (avReq.read || avReq.write) && st_q.bus == BUS_IDLE;
  assign avReaddata = st_q.rdata;
  assign ampToCmpRoute = st_q.route;
  assign syncTrigger = cmpEvent;
  assign timerCaptureIn = cmpOutN[1] & st_q.ctrl[1].aux;
  assign currentSourceOn = st_q.adcB[ADCB_ISRC];
  assign refPinConnect = st_q.adcB[ADCB_REF_PIN];
  assign irq = |(st_q.flags & st_q.irqEn & ieBits);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_flag_set: assert property ((|cmpEvent) |=>
    (st_q.flags & $past(cmpEvent)) == $past(cmpEvent))
    else $error("comparator event did not set its flag");

  a_irq_gate: assert property (irq |->
    |($past(st_q.flags | cmpEvent) & st_q.irqEn & ieBits))
    else $error("interrupt raised with no enabled flag");

  a_capture_route: assert property (!st_q.ctrl[1].aux |-> !timerCaptureIn)
    else $error("capture input driven while routing is off");

  a_isrc_bit: assert property (wrAck && avReq.address == OFF_ADCB |=>
    currentSourceOn == $past(avReq.writedata[ADCB_ISRC]))
    else $error("current source bit not taken from write");

  a_cmp_off: assert property (!st_q.ctrl[0].on |=> !cmpOutN[0] && !syncTrigger[0])
    else $error("disabled comparator shows output or event");

  a_pll_tick: assert property (st_q.ctrl[0].aux && !st_q.route[0] |->
    cmpTick[0] == clkTicks.pll)
    else $error("comparator clock does not follow PLL tick");

  a_bus_answer: assert property ((avReq.read || avReq.write) && avWaitrequest |=>
    !avWaitrequest)
    else $error("bus access not answered after one wait cycle");

  a_ref_pin_bit: assert property (wrAck && avReq.address == OFF_ADCB |=>
    refPinConnect == $past(avReq.writedata[ADCB_REF_PIN]))
    else $error("reference pin bit not taken from write");

  a_adcb_write: assert property (wrAck && avReq.address == OFF_ADCB |=>
    st_q.adcB == $past(wByte & ADCB_WMASK))
    else $error("converter register does not hold the masked write");

  a_full_rate: assert property (!st_q.half |-> ioTick)
    else $error("comparison tick missing at full rate");

  a_io_tick: assert property (!st_q.ctrl[0].aux && !st_q.route[0] |->
    cmpTick[0] == ioTick)
    else $error("comparator clock does not follow the io tick");

  a_plain_tick: assert property (!st_q.ctrl[0].aux |->
    cmpTick[NUM_CMP-1] == ioTick)
    else $error("unrouted comparator clock does not follow the io tick");

  a_ctrl_rsvd: assert property (!st_q.ctrl[2].aux && !st_q.ctrl[3].aux)
    else $error("reserved clock bit set on a later comparator");

  a_ctrl0_write: assert property (wrAck && avReq.address == OFF_CTRL0 |=>
    st_q.ctrl[0] == $past(wByte) && cmpOn[0] == $past(wByte[RW-1]))
    else $error("first control register does not hold the write");

  a_ctrl1_write: assert property (wrAck && avReq.address == OFF_CTRL1 |=>
    st_q.ctrl[1] == $past(wByte) && cmpOn[1] == $past(wByte[RW-1]))
    else $error("second control register does not hold the write");

  a_capture_follow: assert property (st_q.ctrl[1].aux |->
    timerCaptureIn == cmpOutN[1])
    else $error("capture input does not follow the comparator");

  a_en_write: assert property (wrAck && avReq.address == OFF_IRQ_EN |=>
    st_q.irqEn == $past(wByte[NUM_CMP-1:0]))
    else $error("interrupt enable does not hold the write");

  a_clr_write: assert property (wrAck && avReq.address == OFF_IRQ_CLR |=>
    (st_q.flags & $past(wByte[NUM_CMP-1:0] & ~cmpEvent)) == '0)
    else $error("cleared flag still set");

  a_status_ro: assert property (wrAck && (avReq.address == OFF_STATUS ||
    avReq.address == OFF_IRQ_STAT) |=> st_q.flags == $past(st_q.flags | cmpEvent))
    else $error("status write changed the flags");

  a_config_write: assert property (wrAck && avReq.address == OFF_CONFIG |=>
    ampToCmpRoute == $past(wByte[CFG_ROUTE_LO +: NUM_AMP]))
    else $error("routing bits do not hold the write");

  a_read_stands: assert property (!rdStart |=> avReaddata == $past(avReaddata))
    else $error("read data changed without a read");

  a_read_upper: assert property (avReaddata[DW-1:RW] == '0)
    else $error("read data above the register byte not zero");
endmodule : acmpc_ctrl
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acmpc_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  acmpc_avreq_t avReq = '0;
  logic [NUM_CMP-1:0] cmpRaw = '0;
  acmpc_ticks_t clkTicks = '0;
  logic avWaitrequest, currentSourceOn, refPinConnect, irq, timerCaptureIn;
  logic [DW-1:0] avReaddata;
  logic [NUM_CMP-1:0] cmpOn, cmpOutN, syncTrigger;
  acmpc_neg_t [NUM_CMP-1:0] cmpNegSel;
  logic [NUM_AMP-1:0] ampToCmpRoute;
  int n_mismatch = 0;
  int comparisons = 0;
  int nSync = 0;
  int sv[4] = '{0, 2, 3, 1};
  logic [31:0] rd;

  acmpc_ctrl u_dut (.mclk(mclk), .reset(reset), .avReq(avReq),
    .avWaitrequest(avWaitrequest), .avReaddata(avReaddata), .cmpRaw(cmpRaw),
    .clkTicks(clkTicks), .cmpOn(cmpOn), .cmpNegSel(cmpNegSel),
    .ampToCmpRoute(ampToCmpRoute), .cmpOutN(cmpOutN), .syncTrigger(syncTrigger),
    .timerCaptureIn(timerCaptureIn), .currentSourceOn(currentSourceOn),
    .refPinConnect(refPinConnect), .irq(irq));

  always #50 mclk = ~mclk;
  // counts converter sync pulses
  always @(posedge mclk) nSync <= nSync + $countones(syncTrigger);

  task automatic summarize;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    avReq.read <= ~wr;
    avReq.write <= wr;
    avReq.address <= a;
    avReq.writedata <= {24'h000000, d};
    avReq.byteenable <= 4'hF;
    do begin
      @(posedge mclk);
    end while (avWaitrequest !== 1'b0);
    rd = avReaddata;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    @(negedge mclk);
  endtask : wr

  task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask : rdchk

  task automatic setRaw(input int k, input logic v);
    @(posedge mclk);
    cmpRaw[k] <= v;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask : setRaw

  // one-cycle tick: 3 is the pll, 0..2 the amplifiers
  task automatic tick(input int t);
    @(posedge mclk);
    clkTicks <= 4'(1 << t);
    @(posedge mclk);
    clkTicks <= '0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask : tick

  // toggles one decision on eight edges in a row and counts the events
  task automatic flip(input int k, output int n);
    int b;
    b = nSync;
    repeat (8) begin
      @(posedge mclk);
      cmpRaw[k] <= ~cmpRaw[k];
    end
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    n = nSync - b;
  endtask : flip

  initial begin
    int s0;
    int fr;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rdchk(OFF_CTRL0, 32'h0);
    rdchk(OFF_CTRL1, 32'h0);
    rdchk(OFF_ADCB, 32'h0);
    wr(OFF_ADCB, 8'hFF);
    rdchk(OFF_ADCB, 32'hEF);
    chk(32'({currentSourceOn, refPinConnect}), 32'h3);
    wr(OFF_ADCB, 8'h40);
    chk(32'({currentSourceOn, refPinConnect}), 32'h2);
    wr(OFF_ADCB, 8'h20);
    chk(32'({currentSourceOn, refPinConnect}), 32'h1);
    rdchk(6'h3C, 32'h0);
    for (int c = 0; c < 7; c++) begin
      wr(OFF_CTRL0, 8'(8'h80 | c));
      chk(32'({cmpOn[0], cmpNegSel[0]}), 32'(8 + c));
    end
    wr(OFF_CTRL0, 8'h00);
    chk(32'(cmpOn), 32'h0);
    wr(OFF_CTRL1, 8'hC0);
    chk(32'(cmpOn), 32'h2);
    wr(OFF_CTRL1, 8'h00);
    wr(OFF_IRQ_EN, 8'h0F);
    s0 = nSync;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) begin
        wr(OFF_CTRL0 + 6'(4 * k), 8'(8'hC0 | (sv[i] << 4)));
        wr(OFF_IRQ_CLR, 8'h0F);
        setRaw(k, 1'b1);
        fr = int'(sv[i] == 0 || sv[i] == 3);
        chk(32'({irq, cmpOutN}), 32'((fr << 4) | (1 << k)));
        rdchk(OFF_STATUS, 32'((fr << (4 + k)) | (1 << k)));
        wr(OFF_IRQ_CLR, 8'h0F);
        setRaw(k, 1'b0);
        fr = int'(sv[i] == 0 || sv[i] == 2);
        chk(32'({irq, cmpOutN}), 32'(fr << 4));
        rdchk(OFF_STATUS, 32'(fr << (4 + k)));
      end
      wr(OFF_CTRL0 + 6'(4 * k), 8'h00);
    end
    chk(32'(nSync - s0), 32'd16);
    wr(OFF_IRQ_CLR, 8'h0F);
    wr(OFF_CTRL0, 8'hB0);
    setRaw(0, 1'b1);
    rdchk(OFF_STATUS, 32'h11);
    wr(OFF_STATUS, 8'h00);
    rdchk(OFF_STATUS, 32'h11);
    chk(32'(irq), 32'h0);
    wr(OFF_CTRL0, 8'hF0);
    chk(32'(irq), 32'h1);
    setRaw(0, 1'b0);
    wr(OFF_IRQ_CLR, 8'h0F);
    chk(32'(irq), 32'h0);
    wr(OFF_CTRL0, 8'h88);
    setRaw(0, 1'b1);
    chk(32'(cmpOutN), 32'h0);
    tick(3);
    chk(32'(cmpOutN), 32'h1);
    wr(OFF_CTRL0, 8'h80);
    wr(OFF_CONFIG, 8'h02);
    chk(32'(ampToCmpRoute), 32'h1);
    setRaw(0, 1'b0);
    chk(32'(cmpOutN), 32'h1);
    tick(0);
    chk(32'(cmpOutN), 32'h0);
    wr(OFF_CONFIG, 8'h00);
    flip(0, fr);
    chk(32'(fr), 32'd8);
    wr(OFF_CONFIG, 8'h01);
    setRaw(0, 1'b1);
    chk(32'(cmpOutN), 32'h1);
    flip(0, fr);
    chk(32'(fr <= 2), 32'h1);
    wr(OFF_CTRL1, 8'h88);
    setRaw(1, 1'b1);
    chk(32'(timerCaptureIn), 32'h1);
    wr(OFF_CTRL1, 8'h80);
    chk(32'(timerCaptureIn), 32'h0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
endmodule : tb
`default_nettype wire
